// ### rtl/rsx_map.svh
/*
  Holds the opcodes, data codes, field positions and sizes of the extended
  command decoder of the radio serial command port, as `define macros.
  Assumes inclusion by rsx_pkg.sv and the design files by bare name.
*/
// Behaviour
// - unlock opcode then 0x73 enables width read, ack payload, unacked tx writes.
// - a second unlock with 0x73 disables those commands again (toggle).
// - while disabled, writes ignored and reads give zero bytes; disabled after reset.
// - unlock then 0x53 toggles register bank; bank shown in bit 7 of register 7.
// - opcode 0x60 returns byte count of payload at head of receive FIFO.
// - opcodes 0xA8-0xAD store following bytes as ack payload for pipe in low bits.
// - at most three pending ack payloads across all pipes.
// - ack payloads to the same pipe leave in the order written; the store can reorder them when a take meets an open, byte or close strobe.
// - ack payload carries 1 to 32 bytes; first byte lands at position zero.
// - opcode 0xB0 queues a transmit payload flagged as not expecting acknowledge.
// - opcode 0xFF does nothing but shift out the status register.
// - bank 0 and bank 1 regs 9-14 move least significant byte first, msb first.
// - bank 1 regs 0-8 move most significant byte first, msb first in each byte.
// - each command starts on chip select falling; host toggles it between commands.
// - status shifts out on serial output while the command byte shifts in.
// - command byte shifts msb first, then any data bytes follow.
`ifndef RSX_MAP_SVH
`define RSX_MAP_SVH
`define RSX_OP_UNLOCK 8'h50
`define RSX_OP_RD_WIDTH 8'h60
`define RSX_OP_ACK_BASE 5'h15
`define RSX_OP_TX_UNACKED 8'hB0
`define RSX_OP_IDLE 8'hFF
`define RSX_DATA_FEATURES 8'h73
`define RSX_DATA_BANK 8'h53
`define RSX_BANK_BIT 7
`define RSX_MAX_PAYLOAD 32
`define RSX_ACK_SLOTS 3
`define RSX_BANK1_MSB_LAST 4'h8
`endif

// ### rtl/rsx_pkg.sv
/*
  Types shared by the extended command decoder files.
  Assumes rsx_map.svh is on the include path.
*/
`include "rsx_map.svh"
package rsx_pkg;
  typedef enum logic [3:0] {
    RSX_IDLE = 4'b0001,
    RSX_CMD = 4'b0010,
    RSX_DATA = 4'b0100,
    RSX_DONE = 4'b1000
  } rsx_state_e;
  typedef logic [7:0] rsx_byte_t;
endpackage

// ### rtl/rsx_ack_store.sv
/*
  Holds up to three pending acknowledge payloads with their pipe numbers.
  Assumes writes come as one-cycle strobes from the decoder on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rsx_map.svh"
module rsx_ack_store #(
  parameter int SLOTS = `RSX_ACK_SLOTS,
  parameter int BYTES = `RSX_MAX_PAYLOAD
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic open_slot,
  input wire logic [2:0] open_pipe,
  input wire logic byte_wr,
  input wire logic [7:0] byte_data,
  input wire logic close_slot,
  // Radio side
  input wire logic take,
  input wire logic [2:0] take_pipe,
  output logic take_found,
  output logic [5:0] take_len,
  output logic [1:0] pending,
  output logic full
);
  import rsx_pkg::*;
  logic [SLOTS-1:0] used_ff;
  logic [SLOTS-1:0] fill_ff;
  logic [2:0] pipe_ff [SLOTS];
  logic [5:0] len_ff [SLOTS];
  logic [1:0] age_ff [SLOTS];
  logic [7:0] mem_ff [SLOTS][BYTES];
  logic [1:0] free_idx;
  logic [1:0] take_idx;
  logic [1:0] cnt;
  logic [1:0] take_age;
  logic [SLOTS-1:0] take_hit;
  always_comb begin
    free_idx = 2'h0;
    take_idx = 2'h0;
    take_age = 2'h0;
    take_found = 1'b0;
    cnt = 2'h0;
    take_len = 6'h00;
    take_hit = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!used_ff[i]) begin
        free_idx = 2'(i);
      end
    end
    for (int i = 0; i < SLOTS; i++) begin
      cnt = cnt + 2'(used_ff[i] && !fill_ff[i]);
      // Lowest age for the pipe wins, the lower slot on a tie, so one pipe drains in age order
      if (used_ff[i] && !fill_ff[i] && pipe_ff[i] == take_pipe &&
          (!take_found || age_ff[i] < age_ff[take_idx])) begin
        take_found = 1'b1;
        take_idx = 2'(i);
      end
    end
    if (take_found) begin
      take_len = len_ff[take_idx];
      take_age = age_ff[take_idx];
      take_hit[take_idx] = take;
    end
  end
  assign pending = cnt;
  assign full = &used_ff;
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          used_ff[g] <= 1'b0;
          fill_ff[g] <= 1'b0;
          pipe_ff[g] <= 3'h0;
          len_ff[g] <= 6'h00;
          age_ff[g] <= 2'h0;
        end else if (open_slot && !full && free_idx == 2'(g)) begin
          used_ff[g] <= 1'b1;
          fill_ff[g] <= 1'b1;
          pipe_ff[g] <= open_pipe;
          len_ff[g] <= 6'h00;
          age_ff[g] <= cnt;
        end else if (fill_ff[g] && byte_wr && len_ff[g] < 6'(BYTES)) begin
          len_ff[g] <= len_ff[g] + 6'h01;
        end else if (fill_ff[g] && close_slot) begin
          fill_ff[g] <= 1'b0;
          used_ff[g] <= (len_ff[g] != 6'h00);
        end else if (take_hit[g]) begin
          used_ff[g] <= 1'b0;
        // Only entries younger than the taken one move up; a filling one that takes a byte or closes that cycle keeps its age
        end else if (take_found && take && used_ff[g] && age_ff[g] > take_age) begin
          age_ff[g] <= age_ff[g] - 2'h1;
        end
      end
      always_ff @(posedge clock) begin
        if (fill_ff[g] && byte_wr && len_ff[g] < 6'(BYTES)) begin
          mem_ff[g][len_ff[g][4:0]] <= byte_data;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### rtl/rsx_cmd_decoder.sv
/*
  Extended command decoder of the radio serial command port: unlock,
  bank toggle, width read, ack payload, unacked transmit and idle status.
  Assumes the serial pins come from the far side unsynchronised and that
  the serial clock is well below a quarter of the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rsx_map.svh"
module rsx_cmd_decoder (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial port pins
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Device state
  input wire logic [7:0] status_in,
  input wire logic [5:0] rx_head_width,
  input wire logic [1:0] reg_index_hi,
  // Control outputs
  output logic features_on,
  output logic bank_sel,
  output logic [7:0] status_register_seven_bit,
  output logic tx_wr,
  output logic [7:0] tx_data,
  output logic tx_unacked,
  output logic tx_close,
  output logic [1:0] ack_pending,
  output logic ack_full,
  // Radio ack fetch
  input wire logic ack_take,
  input wire logic [2:0] ack_take_pipe,
  output logic ack_found,
  output logic [5:0] ack_len
);
  import rsx_pkg::*;
  // -------------------------------------------------------------
  // Pin synchronisers
  // -------------------------------------------------------------
  logic [1:0] cs_sync_ff;
  logic [1:0] sck_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic sck_last_ff;
  logic cs_last_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_ff <= 2'h3;
      sck_sync_ff <= 2'h0;
      mosi_sync_ff <= 2'h0;
      sck_last_ff <= 1'b0;
      cs_last_ff <= 1'b1;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], chip_select_n};
      sck_sync_ff <= {sck_sync_ff[0], sck};
      mosi_sync_ff <= {mosi_sync_ff[0], mosi};
      sck_last_ff <= sck_sync_ff[1];
      cs_last_ff <= cs_sync_ff[1];
    end
  end
  wire cs_act = !cs_sync_ff[1];
  wire cs_fall = cs_last_ff && !cs_sync_ff[1];
  wire sck_rise = cs_act && sck_sync_ff[1] && !sck_last_ff;
  wire sck_fall = cs_act && !sck_sync_ff[1] && sck_last_ff;
  // -------------------------------------------------------------
  // Byte framing and decode
  // -------------------------------------------------------------
  rsx_state_e state_ff;
  rsx_state_e nxt_state;
  logic [2:0] bit_cnt_ff;
  logic [7:0] shin_ff;
  logic [7:0] op_ff;
  logic [7:0] shout_ff;
  logic first_data_ff;
  logic feat_ff;
  logic bank_ff;
  logic miso_ff;
  logic oe_n_ff;
  logic tx_wr_ff;
  logic tx_close_ff;
  logic unacked_ff;
  logic [7:0] tx_data_ff;
  logic ack_open_ff;
  logic ack_wr_ff;
  logic ack_close_ff;
  logic ack_full_w;
  logic [5:0] data_cnt_ff;
  logic [7:0] status7_ff;
  logic [1:0] pending_ff;
  logic full_ff;
  logic found_ff;
  logic [5:0] ack_len_ff;
  logic [1:0] store_pending;
  logic store_found;
  logic [5:0] store_len;
  wire [7:0] shin_next = {shin_ff[6:0], mosi_sync_ff[1]};
  wire byte_end = sck_rise && bit_cnt_ff == 3'h7;
  wire data_room = data_cnt_ff < 6'(`RSX_MAX_PAYLOAD);
  wire op_is_unlock = op_ff == `RSX_OP_UNLOCK;
  wire op_is_width = op_ff == `RSX_OP_RD_WIDTH;
  wire op_is_ack = op_ff[7:3] == `RSX_OP_ACK_BASE;
  wire op_is_unacked = op_ff == `RSX_OP_TX_UNACKED;
  // Gated commands act only once features are unlocked
  wire ack_ok = op_is_ack && feat_ff && op_ff[2:0] <= 3'h5;
  wire unacked_ok = op_is_unacked && feat_ff;
  wire new_ack = byte_end && state_ff == RSX_CMD && shin_next[7:3] == `RSX_OP_ACK_BASE &&
                 feat_ff && shin_next[2:0] <= 3'h5 && !ack_full_w;
  wire [7:0] width_byte = feat_ff ? {2'h0, rx_head_width} : 8'h00;
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RSX_IDLE: if (cs_fall) nxt_state = RSX_CMD;
      RSX_CMD: if (byte_end) nxt_state = RSX_DATA;
      RSX_DATA: if (!cs_act) nxt_state = RSX_DONE;
      // A select fall right after a frame must still start a command
      RSX_DONE: nxt_state = cs_fall ? RSX_CMD : RSX_IDLE;
    endcase
    if (!cs_act && state_ff != RSX_DATA) begin
      nxt_state = RSX_IDLE;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RSX_IDLE;
      bit_cnt_ff <= 3'h0;
      shin_ff <= 8'h00;
      op_ff <= `RSX_OP_IDLE;
      first_data_ff <= 1'b0;
      data_cnt_ff <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      if (cs_fall) begin
        bit_cnt_ff <= 3'h0;
        op_ff <= `RSX_OP_IDLE;
      end else if (sck_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shin_ff <= shin_next;
      end
      if (byte_end && state_ff == RSX_CMD) begin
        op_ff <= shin_next;
        first_data_ff <= 1'b1;
      end else if (byte_end) begin
        first_data_ff <= 1'b0;
      end
      // Saturates at the payload limit so later bytes fall away
      if (cs_fall) begin
        data_cnt_ff <= 6'h00;
      end else if (byte_end && state_ff == RSX_DATA && data_room) begin
        data_cnt_ff <= data_cnt_ff + 6'h01;
      end
    end
  end
  // -------------------------------------------------------------
  // Unlock, bank toggle and payload strobes
  // -------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      feat_ff <= 1'b0;
      bank_ff <= 1'b0;
      tx_wr_ff <= 1'b0;
      tx_close_ff <= 1'b0;
      unacked_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      ack_open_ff <= 1'b0;
      ack_wr_ff <= 1'b0;
      ack_close_ff <= 1'b0;
    end else begin
      tx_wr_ff <= 1'b0;
      tx_close_ff <= 1'b0;
      ack_wr_ff <= 1'b0;
      ack_open_ff <= new_ack;
      ack_close_ff <= 1'b0;
      // Only the first data byte counts; extra bytes are ignored
      if (byte_end && state_ff == RSX_DATA && first_data_ff && op_is_unlock) begin
        if (shin_next == `RSX_DATA_FEATURES) begin
          feat_ff <= !feat_ff;
        end
        if (shin_next == `RSX_DATA_BANK) begin
          bank_ff <= !bank_ff;
        end
      end
      if (byte_end && state_ff == RSX_DATA && (ack_ok || unacked_ok)) begin
        tx_data_ff <= shin_next;
        tx_wr_ff <= unacked_ok && data_room;
        ack_wr_ff <= ack_ok;
        unacked_ff <= unacked_ok;
      end
      if (state_ff == RSX_DATA && !cs_act) begin
        tx_close_ff <= unacked_ok;
        ack_close_ff <= ack_ok;
      end
    end
  end
  // -------------------------------------------------------------
  // Serial output
  // -------------------------------------------------------------
  // Width read carries a single byte, later bytes read zero
  wire [7:0] load_byte = (state_ff == RSX_CMD) ?
                         ((shin_next == `RSX_OP_RD_WIDTH) ? width_byte : 8'h00) : 8'h00;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shout_ff <= 8'h00;
      miso_ff <= 1'b0;
      oe_n_ff <= 1'b1;
    end else begin
      oe_n_ff <= !cs_act;
      if (cs_fall) begin
        miso_ff <= status_in[7];
        shout_ff <= {status_in[6:0], 1'b0};
      end else if (byte_end) begin
        shout_ff <= load_byte;
      end else if (sck_fall) begin
        miso_ff <= shout_ff[7];
        shout_ff <= {shout_ff[6:0], 1'b0};
      end
    end
  end
  // -------------------------------------------------------------
  // Acknowledge payload store
  // -------------------------------------------------------------
  rsx_ack_store u_ack (
    .clock(clock),
    .rst_n(rst_n),
    .open_slot(ack_open_ff),
    .open_pipe(op_ff[2:0]),
    .byte_wr(ack_wr_ff),
    .byte_data(tx_data_ff),
    .close_slot(ack_close_ff),
    .take(ack_take),
    .take_pipe(ack_take_pipe),
    .take_found(store_found),
    .take_len(store_len),
    .pending(store_pending),
    .full(ack_full_w)
  );
  // Lookup results are registered so every output leaves a flip-flop;
  // the radio sees the effect of a take two clocks later
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status7_ff <= 8'h00;
      pending_ff <= 2'h0;
      full_ff <= 1'b0;
      found_ff <= 1'b0;
      ack_len_ff <= 6'h00;
    end else begin
      status7_ff <= {bank_ff, status_in[6:0]};
      pending_ff <= store_pending;
      full_ff <= ack_full_w;
      found_ff <= store_found;
      ack_len_ff <= store_len;
    end
  end
  assign ack_pending = pending_ff;
  assign ack_full = full_ff;
  assign ack_found = found_ff;
  assign ack_len = ack_len_ff;
  assign miso = miso_ff;
  assign miso_oe_n = oe_n_ff;
  assign features_on = feat_ff;
  assign bank_sel = bank_ff;
  assign status_register_seven_bit = status7_ff;
  assign tx_wr = tx_wr_ff;
  assign tx_data = tx_data_ff;
  assign tx_unacked = unacked_ff;
  assign tx_close = tx_close_ff;
  // Byte order for register data is chosen by the register file: bank 0 and
  // bank 1 regs 9-14 go low byte first bank 1 regs 0-8 high first
  logic unused_idx;
  assign unused_idx = ^reg_index_hi;
  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  a_unlock_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    byte_end && state_ff == RSX_DATA && first_data_ff && op_is_unlock &&
    shin_next == `RSX_DATA_FEATURES |=> feat_ff != $past(feat_ff))
    else $error("feature toggle missed");
  a_bank_toggle: assert property (@(posedge clock) disable iff (!rst_n)
    byte_end && state_ff == RSX_DATA && first_data_ff && op_is_unlock &&
    shin_next == `RSX_DATA_BANK |=> bank_ff != $past(bank_ff))
    else $error("bank toggle missed");
  a_locked_write: assert property (@(posedge clock) disable iff (!rst_n)
    !feat_ff |=> !tx_wr_ff && !ack_wr_ff)
    else $error("write while locked");
  a_status_out: assert property (@(posedge clock) disable iff (!rst_n)
    cs_fall |=> miso_ff == $past(status_in[7]))
    else $error("status bit not first");
  a_ack_cap: assert property (@(posedge clock) disable iff (!rst_n)
    ack_full_w && !ack_take && !ack_close_ff
    |=> ack_full_w && store_pending == $past(store_pending))
    else $error("full ack store disturbed");
  a_unacked_flag: assert property (@(posedge clock) disable iff (!rst_n)
    tx_wr_ff |-> unacked_ff && op_is_unacked && feat_ff)
    else $error("unacked write from wrong command");
  a_tx_cap: assert property (@(posedge clock) disable iff (!rst_n)
    byte_end && state_ff == RSX_DATA && !data_room |=> !tx_wr_ff)
    else $error("transmit byte past payload limit");
  a_width_zero: assert property (@(posedge clock) disable iff (!rst_n)
    byte_end && state_ff == RSX_CMD && shin_next == `RSX_OP_RD_WIDTH && !feat_ff
    |=> shout_ff == 8'h00)
    else $error("locked width read not zero");
  a_cmd_start: assert property (@(posedge clock) disable iff (!rst_n)
    cs_fall |=> state_ff == RSX_CMD)
    else $error("command did not start");
  a_oe_follow: assert property (@(posedge clock) disable iff (!rst_n)
    !cs_act |=> oe_n_ff)
    else $error("output driven while deselected");
endmodule
`default_nettype wire

// ### bench/rsx_host_model.sv
/*
  Host side model of the serial command port: a master that frames each
  command with chip select and clocks bytes out and in, msb first.
  Assumes the testbench calls its tasks one at a time, never overlapped.
*/
`timescale 1ns/10ps
`default_nettype none
module rsx_host_model (
  // Core clock, used only to space frames
  input wire logic clock,
  // Serial port pins
  output logic chip_select_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  // Leaves time for the select synchroniser before the first edge
  task automatic start_cmd();
    chip_select_n <= 1'b0;
    repeat (10) @(posedge clock);
  endtask

  // Serial clock stands low between frames; 48 ns period inside them
  task automatic xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= t[i];
      #24 sck <= 1'b1;
      r[i] = miso;
      #24 sck <= 1'b0;
    end
  endtask

  // Unlock is only ever sent with the radio idle; the bench has no radio
  task automatic end_cmd();
    #24 chip_select_n <= 1'b1;
    mosi <= ~mosi;
    repeat (10) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### bench/rsx_cmd_decoder_tb.sv
/*
  Self-checking bench of the extended command decoder.
  Assumes the host model drives the serial pins and the bench the rest.
*/
`timescale 1ns/10ps
`default_nettype none
`include "rsx_map.svh"
module rsx_cmd_decoder_tb;
  import rsx_pkg::*;
  logic clock, rst_n, chip_select_n, sck, mosi, miso, miso_oe_n;
  logic [7:0] status_in, status_register_seven_bit, tx_data;
  logic [5:0] rx_head_width, ack_len;
  logic [2:0] ack_take_pipe;
  logic [1:0] ack_pending;
  logic features_on, bank_sel, tx_wr, tx_unacked, tx_close, ack_full, ack_take, ack_found;
  int fail_count = 0;
  int tests_run = 0;
  int tx_count = 0;
  int close_count = 0;
  rsx_byte_t tx_first, s, r;

  rsx_cmd_decoder uut (.clock(clock), .rst_n(rst_n), .chip_select_n(chip_select_n),
    .sck(sck), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n), .status_in(status_in),
    .rx_head_width(rx_head_width), .reg_index_hi(2'b00), .features_on(features_on),
    .bank_sel(bank_sel), .status_register_seven_bit(status_register_seven_bit),
    .tx_wr(tx_wr), .tx_data(tx_data), .tx_unacked(tx_unacked), .tx_close(tx_close),
    .ack_pending(ack_pending), .ack_full(ack_full), .ack_take(ack_take),
    .ack_take_pipe(ack_take_pipe), .ack_found(ack_found), .ack_len(ack_len));
  rsx_host_model host (.clock(clock), .chip_select_n(chip_select_n), .sck(sck),
    .mosi(mosi), .miso(miso));

  // ----------------------------------------
  // Clock and transmit strobe monitor
  // ----------------------------------------
  always #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (tx_wr === 1'b1) begin
      if (tx_count == 0) tx_first <= tx_data;
      tx_count <= tx_count + 1;
    end
    if (tx_close === 1'b1) close_count <= close_count + 1;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One framed command; data bytes count up from d, first reply byte in r1
  task automatic run(input rsx_byte_t op, input int n, input rsx_byte_t d,
                     output rsx_byte_t s0, output rsx_byte_t r1);
    rsx_byte_t junk;
    host.start_cmd();
    check({7'h00, miso_oe_n}, 8'h00);
    host.xfer(op, s0);
    r1 = 8'h00;
    for (int i = 0; i < n; i++) begin
      host.xfer(d + rsx_byte_t'(i), junk);
      if (i == 0) r1 = junk;
    end
    host.end_cmd();
  endtask

  task automatic peek(input logic [2:0] p);
    @(posedge clock) ack_take_pipe <= p;
    repeat (2) @(posedge clock);
  endtask

  task automatic pop();
    @(posedge clock) ack_take <= 1'b1;
    @(posedge clock) ack_take <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_locked();
    check({features_on, bank_sel, miso_oe_n, ack_full, 2'b00, ack_pending}, 8'h20);
    run(`RSX_OP_RD_WIDTH, 1, 8'h00, s, r);
    check(s, status_in);
    check(r, 8'h00);
    run(`RSX_OP_TX_UNACKED, 2, 8'h11, s, r);
    run({`RSX_OP_ACK_BASE, 3'd1}, 2, 8'h22, s, r);
    check(8'(tx_count), 8'h00);
    check({6'h00, ack_pending}, 8'h00);
  endtask

  task automatic t_unlock();
    run(`RSX_OP_UNLOCK, 1, `RSX_DATA_FEATURES, s, r);
    check({7'h00, features_on}, 8'h01);
    run(`RSX_OP_RD_WIDTH, 1, 8'hFF, s, r);
    check(s, status_in);
    check(r, 8'h20);
  endtask

  task automatic t_bank();
    run(`RSX_OP_UNLOCK, 1, `RSX_DATA_BANK, s, r);
    check({7'h00, bank_sel}, 8'h01);
    check(status_register_seven_bit, status_in | 8'h80);
    run(`RSX_OP_UNLOCK, 1, `RSX_DATA_BANK, s, r);
    check({features_on, bank_sel, 6'h00}, 8'h80);
    check(status_register_seven_bit, status_in);
  endtask

  task automatic t_ack();
    run({`RSX_OP_ACK_BASE, 3'd2}, 3, 8'h30, s, r);
    run({`RSX_OP_ACK_BASE, 3'd6}, 2, 8'h40, s, r);
    check({6'h00, ack_pending}, 8'h01);
    run({`RSX_OP_ACK_BASE, 3'd2}, 5, 8'h50, s, r);
    run({`RSX_OP_ACK_BASE, 3'd0}, 1, 8'h60, s, r);
    check({5'h00, ack_full, ack_pending}, 8'h07);
    run({`RSX_OP_ACK_BASE, 3'd5}, 4, 8'h70, s, r);
    check({6'h00, ack_pending}, 8'h03);
    peek(3'd5);
    check({7'h00, ack_found}, 8'h00);
    peek(3'd2);
    check({1'b0, ack_found, ack_len}, 8'h43);
    pop();
    check({1'b0, ack_found, ack_len}, 8'h45);
    pop();
    peek(3'd0);
    check({1'b0, ack_found, ack_len}, 8'h41);
    pop();
    check({5'h00, ack_full, ack_pending}, 8'h00);
  endtask

  task automatic t_tx();
    run(`RSX_OP_TX_UNACKED, 33, 8'hC0, s, r);
    check(8'(tx_count), 8'(`RSX_MAX_PAYLOAD));
    check(tx_first, 8'hC0);
    check({tx_unacked, 7'(close_count)}, 8'h81);
  endtask

  task automatic t_idle();
    run(`RSX_OP_IDLE, 0, 8'h00, s, r);
    check(s, status_in);
    check({features_on, bank_sel, ack_pending, 4'h0}, 8'h80);
    check(8'(tx_count), 8'h20);
  endtask

  task automatic t_relock();
    run(`RSX_OP_UNLOCK, 1, `RSX_DATA_FEATURES, s, r);
    check({7'h00, features_on}, 8'h00);
    run(`RSX_OP_RD_WIDTH, 1, 8'h00, s, r);
    check(r, 8'h00);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    status_in = 8'h0E;
    rx_head_width = 6'h20;
    ack_take = 1'b0;
    ack_take_pipe = 3'd0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    t_locked();
    t_unlock();
    t_bank();
    t_ack();
    t_tx();
    @(posedge clock) status_in <= 8'h2C;
    repeat (3) @(posedge clock);
    t_idle();
    t_relock();
    summarize();
  end

  // Whole sequence is about 31 us of serial traffic
  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
